// >>> core/three_level_optical_line_encoder.sv
// transmit line encoder driving three stacked emitter current switches
`timescale 1ns/1ps
`default_nettype none
module three_level_optical_line_encoder
    import line_encoder_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pins from the data source
    input wire logic data_in,
    input wire logic line_code_select,
    // current switch controls
    output logic upper_step_current,
    output logic middle_step_current,
    output logic standing_bias_current
);
    // ==========================================
    // input synchronisers
    logic data_meta_q, data_sync_q, data_prev_q;
    logic sel_meta_q, sel_sync_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            data_meta_q <= 1'b0;
            data_sync_q <= 1'b0;
            data_prev_q <= 1'b0;
            sel_meta_q <= 1'b0;
            sel_sync_q <= 1'b0;
        end else begin
            data_meta_q <= data_in;
            data_sync_q <= data_meta_q;
            data_prev_q <= data_sync_q;
            sel_meta_q <= line_code_select;
            sel_sync_q <= sel_meta_q;
        end
    end
    wire logic edge_seen = data_sync_q ^ data_prev_q;
    wire logic external_mode = sel_sync_q;
    // ==========================================
    // decoding
    function automatic logic is_pulse(input phase_t p);
        return p == phase_pulse;
    endfunction
    // wait load so that pulse plus rest spans exactly one refresh interval
    localparam logic [count_width-1:0] wait_last = interval_last - pulse_last - 10'h001;
    // ==========================================
    // refresh timer
    phase_t phase_q, phase_d;
    logic [count_width-1:0] count_q, count_d;
    always_comb begin
        phase_d = phase_q;
        count_d = count_q - 10'h001;
        if (edge_seen) begin
            // any data edge retriggers the timer with a fresh pulse
            phase_d = phase_pulse;
            count_d = pulse_last;
        end else begin
            case (phase_q)
                phase_pulse: begin
                    if (count_q == count_zero) begin
                        phase_d = phase_wait;
                        count_d = wait_last;
                    end
                end
                phase_wait: begin
                    if (count_q == count_zero) begin
                        phase_d = phase_pulse;
                        count_d = pulse_last;
                    end
                end
                default: begin
                    phase_d = phase_wait;
                    count_d = interval_last;
                end
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_q <= phase_wait;
            count_q <= interval_last;
        end else begin
            phase_q <= phase_d;
            count_q <= count_d;
        end
    end
    // timer output q, forced high in external mode
    wire logic timer_q = external_mode | is_pulse(phase_q);
    wire logic timer_qn = ~timer_q;
    // ==========================================
    // level selection
    // coded: pulse drives data level, otherwise mid
    // external: both steps copy data
    // level uses the edge-detect copy so it switches together with the timer restart
    wire logic upper_d = timer_q & data_prev_q;
    wire logic middle_d = (timer_q & data_prev_q) | timer_qn;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            upper_step_current <= 1'b0;
            middle_step_current <= 1'b1;
            standing_bias_current <= 1'b1;
        end else begin
            upper_step_current <= upper_d;
            middle_step_current <= middle_d;
            standing_bias_current <= 1'b1;
        end
    end
    // ==========================================
    // checks
    // cycles since the last pulse start, to check the refresh spacing
    logic [count_width-1:0] gap_q;
    wire logic pulse_start = is_pulse(phase_d) && (!is_pulse(phase_q) || edge_seen);
    always_ff @(posedge clock) begin
        if (!rst_n || pulse_start) begin
            gap_q <= count_zero;
        end else begin
            gap_q <= gap_q + 10'h001;
        end
    end
    logic [count_width-1:0] pulse_len_q;
    always_ff @(posedge clock) begin
        if (!rst_n || !is_pulse(phase_q) || edge_seen) begin
            pulse_len_q <= count_zero;
        end else begin
            pulse_len_q <= pulse_len_q + 10'h001;
        end
    end
    // ==========================================
    // assertions
    property p_bias_on;
        @(posedge clock) disable iff (!rst_n) $past(rst_n) |-> standing_bias_current;
    endproperty
    a_bias_on: assert property (p_bias_on) else $error("bias switch off");
    property p_level_order;
        @(posedge clock) disable iff (!rst_n) upper_step_current |-> middle_step_current;
    endproperty
    a_level_order: assert property (p_level_order) else $error("upper without middle");
    property p_edge_retrigger;
        @(posedge clock) disable iff (!rst_n) edge_seen |=> phase_q == phase_pulse && count_q == pulse_last;
    endproperty
    a_edge_retrigger: assert property (p_edge_retrigger) else $error("edge did not retrigger");
    property p_pulse_width;
        @(posedge clock) disable iff (!rst_n) is_pulse(phase_q) |-> pulse_len_q <= pulse_last;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("refresh pulse too long");
    property p_refresh_period;
        @(posedge clock) disable iff (!rst_n)
            (phase_q == phase_wait && count_q == count_zero && !edge_seen) |=> phase_q == phase_pulse;
    endproperty
    a_refresh_period: assert property (p_refresh_period) else $error("refresh pulse missing");
    property p_external_copy;
        @(posedge clock) disable iff (!rst_n)
            external_mode |=> upper_step_current == $past(data_prev_q) && middle_step_current == $past(data_prev_q);
    endproperty
    a_external_copy: assert property (p_external_copy) else $error("output not copying data");
    property p_coded_rest;
        @(posedge clock) disable iff (!rst_n)
            (!external_mode && phase_q == phase_wait) |=> middle_step_current && !upper_step_current;
    endproperty
    a_coded_rest: assert property (p_coded_rest) else $error("not resting at mid level");
    property p_coded_low;
        @(posedge clock) disable iff (!rst_n)
            (!external_mode && phase_q == phase_pulse && !data_prev_q) |=> !middle_step_current;
    endproperty
    a_coded_low: assert property (p_coded_low) else $error("low pulse wrong");
    c_rise: cover property (@(posedge clock) disable iff (!rst_n) !external_mode && edge_seen && data_sync_q);
    c_fall: cover property (@(posedge clock) disable iff (!rst_n) !external_mode && edge_seen && !data_sync_q);
    c_cut: cover property (@(posedge clock) disable iff (!rst_n) phase_q == phase_pulse && count_q != pulse_last
        && edge_seen);
    c_ext: cover property (@(posedge clock) disable iff (!rst_n) external_mode && upper_step_current);
    c_refresh: cover property (@(posedge clock) disable iff (!rst_n) pulse_start && !edge_seen);
    property p_coded_high;
        @(posedge clock) disable iff (!rst_n)
            (!external_mode && is_pulse(phase_q) && data_prev_q) |=> upper_step_current && middle_step_current;
    endproperty
    a_coded_high: assert property (p_coded_high) else $error("high pulse wrong");
    property p_forced_timer;
        @(posedge clock) disable iff (!rst_n) external_mode |-> timer_q && !timer_qn;
    endproperty
    a_forced_timer: assert property (p_forced_timer) else $error("timer output not forced");
    property p_cut_restart;
        @(posedge clock) disable iff (!rst_n) (edge_seen && is_pulse(phase_q)) |=> pulse_len_q == count_zero;
    endproperty
    a_cut_restart: assert property (p_cut_restart) else $error("pulse not cut on edge");
    property p_pulse_end;
        @(posedge clock) disable iff (!rst_n)
            (is_pulse(phase_q) && count_q == count_zero && !edge_seen) |=> !is_pulse(phase_q);
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse not ended");
    property p_wait_load;
        @(posedge clock) disable iff (!rst_n)
            (is_pulse(phase_q) && count_q == count_zero && !edge_seen) |=> count_q == wait_last;
    endproperty
    a_wait_load: assert property (p_wait_load) else $error("rest length wrong");
    property p_external_pair;
        @(posedge clock) disable iff (!rst_n) external_mode |=> upper_step_current == middle_step_current;
    endproperty
    a_external_pair: assert property (p_external_pair) else $error("step switches differ");
    property p_edge_level;
        @(posedge clock) disable iff (!rst_n)
            (!external_mode && edge_seen) ##1 !external_mode |=> upper_step_current == $past(data_prev_q)
            && middle_step_current == $past(data_prev_q);
    endproperty
    a_edge_level: assert property (p_edge_level) else $error("edge pulse level wrong");
    property p_refresh_spacing;
        @(posedge clock) disable iff (!rst_n)
            (pulse_start && !edge_seen) |-> gap_q == interval_last;
    endproperty
    a_refresh_spacing: assert property (p_refresh_spacing) else $error("refresh gap wrong");
    property p_release_mid;
        @(posedge clock) disable iff (!rst_n)
            !$past(rst_n) |-> middle_step_current && !upper_step_current && standing_bias_current;
    endproperty
    a_release_mid: assert property (p_release_mid) else $error("not mid level after reset");
    property p_upper_needs_data;
        @(posedge clock) disable iff (!rst_n) !data_prev_q |=> !upper_step_current;
    endproperty
    a_upper_needs_data: assert property (p_upper_needs_data) else $error("upper on with data low");
    property p_pulse_count_bound;
        @(posedge clock) disable iff (!rst_n) is_pulse(phase_q) |-> count_q <= pulse_last;
    endproperty
    a_pulse_count_bound: assert property (p_pulse_count_bound) else $error("pulse count out of range");
endmodule
`default_nettype wire

// >>> core/line_encoder_pkg.sv
// constants and states for the three-level optical line encoder
// Behaviour
// - line code select low gives the internally coded three-level pulse code mode.
// - standing bias current switch stays on in both modes.
// - low is bias only; mid adds middle step; high adds upper step too.
// - at 500 kHz data, exactly one refresh pulse per input logic state.
// - every data transition restarts the refresh timer and its pulse train.
// - refresh pulses have one fixed width in both data states.
// - a data transition during a refresh pulse cuts that pulse short at once.
// - refresh interval long against pulse width, duty factor about two percent.
// - line code select high forces timer output high and its complement low.
// - externally coded mode: both step currents follow the data input.
package line_encoder_pkg;
    // ==========================================
    // timing
    localparam int clock_period_ps = 4000;
    // refresh interval 1.96 us: 500 kHz half period of 1 us holds one pulse
    localparam int refresh_interval_ns = 1960;
    // pulse width 40 ns, about 2 percent of the interval
    localparam int refresh_pulse_ns = 40;
    localparam int interval_cycles = (refresh_interval_ns * 1000) / clock_period_ps;
    localparam int pulse_cycles = (refresh_pulse_ns * 1000 + clock_period_ps - 1) / clock_period_ps;
    localparam int count_width = 10;
    localparam logic [count_width-1:0] interval_last = count_width'(interval_cycles - 1);
    localparam logic [count_width-1:0] pulse_last = count_width'(pulse_cycles - 1);
    localparam logic [count_width-1:0] count_zero = 10'h000;
    // ==========================================
    // timer phase
    typedef enum logic [1:0] {
        phase_pulse = 2'b01,
        phase_wait = 2'b10
    } phase_t;
endpackage

// >>> verif/line_source_model.sv
// data source model driving the encoder's data and mode pins
`timescale 1ns/1ps
`default_nettype none
module line_source_model (
    // clock
    input wire logic clock,
    // pins to the encoder
    output logic data_out,
    output logic select_out
);
    initial begin
        data_out = 1'b0;
        select_out = 1'b0;
    end
    // one level change on the falling edge
    task automatic drive(input logic sel, input logic d);
        @(negedge clock);
        select_out = sel;
        data_out = d;
    endtask
    // balanced square wave, halves well above the minimum and under 5 us
    task automatic square(input int half, input int n);
        for (int i = 0; i < n; i++) begin
            drive(select_out, ~data_out);
            repeat (half - 1) @(negedge clock);
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_three_level_optical_line_encoder.sv
// self-checking testbench for the three-level optical line encoder
`timescale 1ns/1ps
`default_nettype none
module tb_three_level_optical_line_encoder;
    import line_encoder_pkg::*;
    // ========================================
    // levels as {bias, upper, middle}
    localparam logic [2:0] hi = 3'h7;
    localparam logic [2:0] mid = 3'h5;
    localparam logic [2:0] lo = 3'h4;
    logic clock;
    logic rst_n;
    wire data_in;
    wire line_code_select;
    logic upper_step_current, middle_step_current, standing_bias_current;
    wire [2:0] lvl = {standing_bias_current, upper_step_current, middle_step_current};
    int errors = 0;
    int checks = 0;
    int pulses = 0;
    logic [2:0] prev_q = 3'h5;
    line_source_model src (.clock(clock), .data_out(data_in), .select_out(line_code_select));
    three_level_optical_line_encoder DUT (.clock(clock), .rst_n(rst_n), .data_in(data_in),
        .line_code_select(line_code_select), .upper_step_current(upper_step_current),
        .middle_step_current(middle_step_current), .standing_bias_current(standing_bias_current));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(negedge clock) begin
        if (lvl !== mid && prev_q === mid) pulses++;
        prev_q <= lvl;
    end
    // ========================================
    // compare tasks
    task automatic cmp(input logic [2:0] e, input logic [2:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR level expected %h seen %h at %0t", e, g, $time);
        end
    endtask
    task automatic cmp_count(input int e, input int g);
        checks++;
        if (g != e) begin
            errors++;
            $display("ERROR pulse count expected %0d seen %0d", e, g);
        end
    endtask
    task automatic lvl_is(input int n, input logic [2:0] e);
        repeat (n) begin
            @(negedge clock);
            cmp(e, lvl);
        end
    endtask
    // ========================================
    // scenarios
    task automatic t_rise();
        src.drive(1'b0, 1'b1);
        lvl_is(3, mid);
        lvl_is(10, hi);
        lvl_is(480, mid);
        lvl_is(10, hi);
        lvl_is(1, mid);
    endtask
    task automatic t_fall();
        src.drive(1'b0, 1'b0);
        lvl_is(3, mid);
        lvl_is(10, lo);
        lvl_is(480, mid);
        lvl_is(10, lo);
    endtask
    task automatic t_cut();
        src.drive(1'b0, 1'b1);
        lvl_is(3, mid);
        lvl_is(4, hi);
        src.drive(1'b0, 1'b0);
        lvl_is(3, hi);
        lvl_is(10, lo);
        lvl_is(1, mid);
    endtask
    task automatic t_500k();
        lvl_is(20, mid);
        pulses = 0;
        src.square(250, 4);
        lvl_is(10, mid);
        cmp_count(4, pulses);
    endtask
    task automatic t_ext();
        src.drive(1'b1, 1'b0);
        lvl_is(2, mid);
        lvl_is(600, lo);
        src.drive(1'b1, 1'b1);
        lvl_is(3, lo);
        lvl_is(600, hi);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #40000;
        errors++;
        end_of_test();
    end
    initial begin
        rst_n = 1'b0;
        lvl_is(5, mid);
        rst_n = 1'b1;
        t_rise();
        t_fall();
        t_cut();
        t_500k();
        t_ext();
        end_of_test();
    end
endmodule
`default_nettype wire
